// ==== timing_master_config_map.vh ====
// Register offsets, field positions, reset values and timing counts of the master configuration bank.
`ifndef TIMING_MASTER_CONFIG_MAP_VH
`define TIMING_MASTER_CONFIG_MAP_VH
`define ADDR_INPUT_NINE_VALID_OVERRIDE 7'h31
`define ADDR_MASTER_CONFIG_ONE 7'h32
`define ADDR_PRIMARY_REFERENCE_FORCE 7'h33
`define ADDR_MASTER_CONFIG_THREE 7'h34
`define ADDR_SECONDARY_LOCK_AND_FORCE 7'h35
`define ADDR_RESERVED_AND_INPUT_FORMAT 7'h36
`define RST_INPUT_NINE_VALID_OVERRIDE 8'h01
`define RST_MASTER_CONFIG_ONE 8'h20
`define RST_PRIMARY_REFERENCE_FORCE 8'h0f
`define RST_MASTER_CONFIG_THREE_FIXED 8'hca
`define RST_SECONDARY_LOCK_AND_FORCE 8'h00
`define RST_RESERVED_AND_INPUT_FORMAT 8'h00
`define BIT_SOFT_RESET 7
`define BIT_INPUT_FREQUENCY_CODE_RANGE_DETECT_ENABLE 5
`define BIT_LOCK_INDICATOR_ENABLE 4
`define BIT_AUTO_FRAME_SYNC_ENABLE 7
`define BIT_PHASE_ALARM_TIMEOUT 6
`define BIT_OSCILLATOR_EDGE_SELECT 5
`define BIT_FREE_RUN_HOLDOVER 4
`define BIT_FRAME_SYNC_ENABLE 3
`define BIT_RATE_FAMILY_SELECT 2
`define BIT_REVERTIVE_SELECT 0
`define BIT_LOCK_SECONDARY_TO_PRIMARY 7
`define STATE_AUTO 3'h0
`define STATE_FREE_RUN 3'h1
`define STATE_HOLDOVER 3'h2
`define STATE_LOCKED 3'h4
`define STATE_PRELOCKED2 3'h5
`define STATE_PRELOCKED 3'h6
`define STATE_LOSS_OF_LOCK 3'h7
`define FORCE_AUTO_LOW 4'h0
`define FORCE_AUTO_HIGH 4'hf
`define FORCE_INPUT_EIGHT 4'h8
`define FORCE_INPUT_NINE 4'h9
`define FORCE_LAST_LOW_INPUT 4'h6
`define PHASE_ALARM_TIMEOUT_S 128
`define CLK_HZ 100000000
`endif

// ==== timing_master_config_regs.v ====
// Master configuration register bank of the timing device with its control decode.
`timescale 1ns/100ps
`include "timing_master_config_map.vh"

// Functional notes
// [RULE1] Input nine override 0 forces input nine invalid; 1 leaves normal monitoring.
// [RULE2] Soft reset bit holds logic in reset; all fields default except itself.
// [RULE3] Strapped fields restore last hardware-reset capture during soft reset, no resample.
// [RULE4] Range detect enable gates quick inactive declaration from frequency measurement.
// [RULE5] Lock pin driven high when enabled and primary state is locked.
// [RULE6] State-force codes: auto, free-run, holdover, locked, prelocked2, prelocked, loss.
// [RULE7] Nonzero state-force holds primary state machine in forced state, ignoring events.
// [RULE8] Primary force codes select inputs 1-6, 8, 9; 0000 and 1111 automatic.
// [RULE9] Revertive: forced input selected at once; nonrevertive: when current one fails.
// [RULE10] Invalid forced reference: no switching; monitors continue; holdover on events.
// [RULE11] Single-sync: auto bit 1 also requires lock to configured source.
// [RULE12] Triple-sync with auto bit: clear frame-sync enable on reference change.
// [RULE13] Timeout bit 1 cancels phase alarms after 128 seconds; else software only.
// [RULE14] Oscillator edge bit: 0 rising, 1 falling.
// [RULE15] Free-run holdover bit forces 0ppm holdover offset.
// [RULE16] Frame-sync enable gates sync input pins.
// [RULE17] Rate family bit picks 2048 or 1544 kHz; default latched from strap.
// [RULE18] Revertive higher-priority valid input selected at once; secondary always revertive.
// [RULE19] Lock-secondary bit with APLL source 0 derives all outputs from primary.
// [RULE20] Secondary force uses same codes, selected at once, no switch when invalid.
// [RULE21] Four spare top bits of sixth register are plain read/write storage.
// [RULE22] Input format bits read back but do not affect input pins.
// [RULE23] Forced-invalid input omitted from priority table; validity status unchanged.
// [RULE24] Registers are 8 bits and read back last written value unless hardware clears; 0x31, 0x33 and 0x35 keep only their defined bits, the rest read 0.
module timing_master_config_regs #(
    parameter ALARM_TIMEOUT_CYCLES = 64'h1 * `PHASE_ALARM_TIMEOUT_S * `CLK_HZ
) (
    // Clock and reset.
    input wire sys_clk,
    input wire rst_n,
    // Strap pin.
    input wire rate_family_strap,
    // Register port.
    input wire [6:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // Status from the surrounding timing logic.
    input wire [2:0] primary_state,
    input wire primary_ref_changed,
    input wire triple_sync_pin_mode,
    input wire locked_to_sync_source,
    input wire input_nine_monitor_valid,
    input wire phase_alarm_active,
    input wire sync_pulse_in,
    // Lock pin.
    output wire lock_pin_out,
    output wire lock_pin_oe,
    // Controls to the surrounding timing logic, and the APLL source setting taken in from it.
    output wire logic_reset,
    output wire input_nine_valid,
    output wire input_frequency_code_range_detect_enable,
    output wire [2:0] primary_state_force,
    output wire state_force_active,
    output wire [3:0] primary_ref_force_field,
    output wire primary_force_active,
    output wire [3:0] primary_force_input,
    output wire primary_force_immediate,
    output wire revertive_select,
    output wire secondary_revertive,
    output wire frame_sync_gate,
    output wire sync_pulse_accepted,
    output wire phase_alarm_cancel,
    output wire oscillator_edge_select,
    output wire free_run_holdover,
    output wire rate_family_select,
    output wire all_outputs_from_primary,
    output wire apll_source_select,
    input wire apll_source_cfg,
    output wire [3:0] secondary_ref_force_field,
    output wire secondary_force_active,
    output wire [3:0] secondary_force_input,
    output wire [3:0] input_format_bits
);

    reg [7:0] input_nine_valid_override_reg;
    reg [7:0] master_config_one_reg;
    reg [7:0] primary_reference_force_reg;
    reg [7:0] master_config_three_reg;
    reg [7:0] secondary_lock_and_force_reg;
    reg [7:0] reserved_and_input_format_reg;
    reg strap_reg;
    reg strap_single_sync_pin_mode_reg;
    reg strap_sync2_reg;
    reg sync_pin1_reg;
    reg sync_pin2_reg;
    reg [63:0] alarm_count_reg;
    reg alarm_cancel_reg;

    wire soft_reset = master_config_one_reg[`BIT_SOFT_RESET];
    wire wr_ok = reg_wr && !soft_reset;
    wire [7:0] master_config_three_default = `RST_MASTER_CONFIG_THREE_FIXED |
                              ({7'h00, strap_reg} << `BIT_RATE_FAMILY_SELECT);

    function force_code_ok;
        input [3:0] code;
        begin
            force_code_ok = (code != `FORCE_AUTO_LOW && code <= `FORCE_LAST_LOW_INPUT) ||
                            code == `FORCE_INPUT_EIGHT || code == `FORCE_INPUT_NINE;
        end
    endfunction

    // The strap is synchronised, then captured only while the hardware reset is held.
    always @(posedge sys_clk) begin
        strap_single_sync_pin_mode_reg <= rate_family_strap;
        strap_sync2_reg <= strap_single_sync_pin_mode_reg;
        if (!rst_n) begin
            strap_reg <= strap_sync2_reg; // [RULE17]
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            master_config_one_reg <= `RST_MASTER_CONFIG_ONE;
        end else if (reg_wr && reg_addr == `ADDR_MASTER_CONFIG_ONE) begin
            master_config_one_reg <= soft_reset ? {reg_wdata[7], master_config_one_reg[6:0]} : reg_wdata;
        end else if (soft_reset) begin
            master_config_one_reg <= `RST_MASTER_CONFIG_ONE | 8'h80; // [RULE2]
        end
    end

    // Soft reset reloads defaults but reuses the captured strap, so the pin is not resampled.
    always @(posedge sys_clk) begin
        if (!rst_n || soft_reset) begin // [RULE2]
            input_nine_valid_override_reg <= `RST_INPUT_NINE_VALID_OVERRIDE;
            primary_reference_force_reg <= `RST_PRIMARY_REFERENCE_FORCE;
            master_config_three_reg <= !rst_n ? (`RST_MASTER_CONFIG_THREE_FIXED |
                                       ({7'h00, strap_sync2_reg} << `BIT_RATE_FAMILY_SELECT)) :
                                       master_config_three_default; // [RULE3]
            secondary_lock_and_force_reg <= `RST_SECONDARY_LOCK_AND_FORCE;
            reserved_and_input_format_reg <= `RST_RESERVED_AND_INPUT_FORMAT;
        end else begin
            if (wr_ok && reg_addr == `ADDR_INPUT_NINE_VALID_OVERRIDE) begin
                input_nine_valid_override_reg <= {7'h00, reg_wdata[0]};
            end
            if (wr_ok && reg_addr == `ADDR_PRIMARY_REFERENCE_FORCE) begin
                primary_reference_force_reg <= {4'h0, reg_wdata[3:0]};
            end
            if (wr_ok && reg_addr == `ADDR_MASTER_CONFIG_THREE) begin
                master_config_three_reg <= reg_wdata; // [RULE24]
            end
            // The hardware clear wins over a simultaneous software set of the enable bit.
            if (triple_sync_pin_mode && master_config_three_reg[`BIT_AUTO_FRAME_SYNC_ENABLE] &&
                primary_ref_changed) begin
                master_config_three_reg[`BIT_FRAME_SYNC_ENABLE] <= 1'b0; // [RULE12]
            end
            if (wr_ok && reg_addr == `ADDR_SECONDARY_LOCK_AND_FORCE) begin
                secondary_lock_and_force_reg <= {reg_wdata[7], 3'h0, reg_wdata[3:0]};
            end
            if (wr_ok && reg_addr == `ADDR_RESERVED_AND_INPUT_FORMAT) begin
                reserved_and_input_format_reg <= reg_wdata; // [RULE21] [RULE22]
            end
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `ADDR_INPUT_NINE_VALID_OVERRIDE: reg_rdata <= input_nine_valid_override_reg;
                `ADDR_MASTER_CONFIG_ONE: reg_rdata <= master_config_one_reg;
                `ADDR_PRIMARY_REFERENCE_FORCE: reg_rdata <= primary_reference_force_reg;
                `ADDR_MASTER_CONFIG_THREE: reg_rdata <= master_config_three_reg;
                `ADDR_SECONDARY_LOCK_AND_FORCE: reg_rdata <= secondary_lock_and_force_reg;
                `ADDR_RESERVED_AND_INPUT_FORMAT: reg_rdata <= reserved_and_input_format_reg;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    always @(posedge sys_clk) begin
        sync_pin1_reg <= sync_pulse_in;
        sync_pin2_reg <= sync_pin1_reg;
    end

    // Alarm timer restarts whenever no alarm is standing or the timeout mode is off.
    always @(posedge sys_clk) begin
        if (!rst_n || soft_reset || !phase_alarm_active ||
            !master_config_three_reg[`BIT_PHASE_ALARM_TIMEOUT]) begin
            alarm_count_reg <= 64'h0;
            alarm_cancel_reg <= 1'b0;
        end else if (alarm_count_reg >= ALARM_TIMEOUT_CYCLES - 1) begin
            alarm_count_reg <= 64'h0;
            alarm_cancel_reg <= 1'b1; // [RULE13]
        end else begin
            alarm_count_reg <= alarm_count_reg + 64'h1;
            alarm_cancel_reg <= 1'b0;
        end
    end

    assign phase_alarm_cancel = alarm_cancel_reg;
    assign logic_reset = soft_reset; // [RULE2]
    assign input_nine_valid = input_nine_valid_override_reg[0] && input_nine_monitor_valid; // [RULE1] [RULE23]
    assign input_frequency_code_range_detect_enable = master_config_one_reg[`BIT_INPUT_FREQUENCY_CODE_RANGE_DETECT_ENABLE]; // [RULE4]
    assign lock_pin_oe = master_config_one_reg[`BIT_LOCK_INDICATOR_ENABLE]; // [RULE5]
    assign lock_pin_out = lock_pin_oe && primary_state == `STATE_LOCKED; // [RULE5]
    assign primary_state_force = master_config_one_reg[2:0]; // [RULE6]
    assign state_force_active = primary_state_force != `STATE_AUTO; // [RULE7]
    assign primary_ref_force_field = primary_reference_force_reg[3:0];
    assign primary_force_active = force_code_ok(primary_ref_force_field); // [RULE8] [RULE10]
    assign primary_force_input = primary_force_active ? primary_ref_force_field : 4'h0; // [RULE8]
    assign revertive_select = master_config_three_reg[`BIT_REVERTIVE_SELECT]; // [RULE18]
    assign primary_force_immediate = primary_force_active && revertive_select; // [RULE9]
    assign secondary_revertive = 1'b1; // [RULE18]
    assign frame_sync_gate = master_config_three_reg[`BIT_FRAME_SYNC_ENABLE] &&
        (triple_sync_pin_mode || !master_config_three_reg[`BIT_AUTO_FRAME_SYNC_ENABLE] ||
         locked_to_sync_source); // [RULE11]
    assign sync_pulse_accepted = frame_sync_gate && sync_pin2_reg; // [RULE16]
    assign oscillator_edge_select = master_config_three_reg[`BIT_OSCILLATOR_EDGE_SELECT]; // [RULE14]
    assign free_run_holdover = master_config_three_reg[`BIT_FREE_RUN_HOLDOVER]; // [RULE15]
    assign rate_family_select = master_config_three_reg[`BIT_RATE_FAMILY_SELECT]; // [RULE17]
    assign apll_source_select = apll_source_cfg;
    assign all_outputs_from_primary = secondary_lock_and_force_reg[`BIT_LOCK_SECONDARY_TO_PRIMARY] &&
                                      !apll_source_cfg; // [RULE19]
    assign secondary_ref_force_field = secondary_lock_and_force_reg[3:0];
    assign secondary_force_active = force_code_ok(secondary_ref_force_field); // [RULE20]
    assign secondary_force_input = secondary_force_active ? secondary_ref_force_field : 4'h0; // [RULE20]
    // Format bits are exported for read-back only; nothing in the input path uses them.
    assign input_format_bits = reserved_and_input_format_reg[3:0]; // [RULE22]

endmodule

// ==== timing_master_config_tail.v ====
// Companion unit of the configuration bank with no logic of its own.
`timescale 1ns/100ps

// ==== timing_master_config_checker.sv ====
// Port-level assertions for the master configuration register bank.
`timescale 1ns/100ps
module timing_master_config_checker (
    // Clock and reset.
    input wire sys_clk,
    input wire rst_n,
    // Status inputs.
    input wire [2:0] primary_state,
    input wire input_nine_monitor_valid,
    input wire apll_source_cfg,
    // Outputs under watch.
    input wire lock_pin_out,
    input wire lock_pin_oe,
    input wire input_nine_valid,
    input wire [2:0] primary_state_force,
    input wire state_force_active,
    input wire [3:0] primary_ref_force_field,
    input wire primary_force_active,
    input wire [3:0] primary_force_input,
    input wire primary_force_immediate,
    input wire revertive_select,
    input wire secondary_revertive,
    input wire [3:0] secondary_ref_force_field,
    input wire secondary_force_active,
    input wire [3:0] secondary_force_input,
    input wire frame_sync_gate,
    input wire sync_pulse_accepted,
    input wire all_outputs_from_primary
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Codes that name an input; all others fall back to automatic selection.
    function automatic logic legal(input logic [3:0] c);
        return (c >= 4'h1 && c <= 4'h6) || c == 4'h8 || c == 4'h9;
    endfunction
    lock_pin_a: assert property (lock_pin_out == (lock_pin_oe && primary_state == 3'h4))
        else $error("lock pin level wrong");
    nine_invalid_a: assert property (!input_nine_monitor_valid |-> !input_nine_valid)
        else $error("input nine valid without monitor");
    state_force_a: assert property (state_force_active == (primary_state_force != 3'h0))
        else $error("state force flag wrong");
    pri_force_a: assert property (primary_force_active == legal(primary_ref_force_field))
        else $error("primary force flag wrong");
    pri_input_a: assert property (primary_force_input == (legal(primary_ref_force_field) ? primary_ref_force_field : 4'h0))
        else $error("primary force input wrong");
    immediate_a: assert property (primary_force_immediate == (primary_force_active && revertive_select))
        else $error("force immediate wrong");
    sec_revertive_select_a: assert property (secondary_revertive)
        else $error("secondary not revertive");
    sec_force_a: assert property (secondary_force_active == legal(secondary_ref_force_field))
        else $error("secondary force flag wrong");
    out_primary_a: assert property (all_outputs_from_primary |-> !apll_source_cfg)
        else $error("outputs from primary with apll source set");
    sync_gate_a: assert property (sync_pulse_accepted |-> frame_sync_gate)
        else $error("sync pulse accepted while gated");
    cover property (lock_pin_out);
    cover property (primary_force_immediate);
    cover property (sync_pulse_accepted);
endmodule
bind timing_master_config_regs timing_master_config_checker i_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .primary_state(primary_state), .input_nine_monitor_valid(input_nine_monitor_valid),
    .apll_source_cfg(apll_source_cfg), .lock_pin_out(lock_pin_out), .lock_pin_oe(lock_pin_oe),
    .input_nine_valid(input_nine_valid), .primary_state_force(primary_state_force),
    .state_force_active(state_force_active), .primary_ref_force_field(primary_ref_force_field),
    .primary_force_active(primary_force_active), .primary_force_input(primary_force_input),
    .primary_force_immediate(primary_force_immediate), .revertive_select(revertive_select),
    .secondary_revertive(secondary_revertive), .secondary_ref_force_field(secondary_ref_force_field),
    .secondary_force_active(secondary_force_active), .secondary_force_input(secondary_force_input),
    .frame_sync_gate(frame_sync_gate), .sync_pulse_accepted(sync_pulse_accepted),
    .all_outputs_from_primary(all_outputs_from_primary));

// ==== test_timing_master_config_regs.sv ====
// Self-checking bench for the master configuration register bank.
`timescale 1ns/100ps
module test_timing_master_config_regs;
    logic sys_clk, rst_n, rate_family_strap, reg_wr, reg_rd, primary_ref_changed, triple_sync_pin_mode;
    logic locked_to_sync_source, input_nine_monitor_valid, phase_alarm_active, sync_pulse_in, apll_source_cfg;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [2:0] primary_state;
    wire [7:0] reg_rdata;
    wire [2:0] psf;
    wire [3:0] prf, pfi, srf, sfi, ifb;
    wire lpo, lpoe, lrst, n9v, fre, sfa, pfa, pfim, rev, srev, fsg, spa, pac, oes, frh, rfs, aop, ass, sfact;
    int mismatches = 0;
    int comparisons = 0;
    int n;
    logic ok;
    logic [7:0] rv [6] = '{8'h01, 8'h20, 8'h0f, 8'hce, 8'h00, 8'h00};
    logic [7:0] wv [6] = '{8'hff, 8'h15, 8'hf9, 8'h73, 8'hf6, 8'ha5};
    logic [7:0] xv [6] = '{8'h01, 8'h15, 8'h09, 8'h73, 8'h86, 8'ha5};
    // A short timeout keeps the alarm scenario inside a few dozen cycles.
    timing_master_config_regs #(.ALARM_TIMEOUT_CYCLES(20)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .rate_family_strap(rate_family_strap), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .primary_state(primary_state),
        .primary_ref_changed(primary_ref_changed), .triple_sync_pin_mode(triple_sync_pin_mode),
        .locked_to_sync_source(locked_to_sync_source), .input_nine_monitor_valid(input_nine_monitor_valid),
        .phase_alarm_active(phase_alarm_active), .sync_pulse_in(sync_pulse_in), .lock_pin_out(lpo),
        .lock_pin_oe(lpoe), .logic_reset(lrst), .input_nine_valid(n9v), .input_frequency_code_range_detect_enable(fre),
        .primary_state_force(psf), .state_force_active(sfa), .primary_ref_force_field(prf),
        .primary_force_active(pfa), .primary_force_input(pfi), .primary_force_immediate(pfim),
        .revertive_select(rev), .secondary_revertive(srev), .frame_sync_gate(fsg), .sync_pulse_accepted(spa),
        .phase_alarm_cancel(pac), .oscillator_edge_select(oes), .free_run_holdover(frh),
        .rate_family_select(rfs), .all_outputs_from_primary(aop), .apll_source_select(ass),
        .apll_source_cfg(apll_source_cfg), .secondary_ref_force_field(srf), .secondary_force_active(sfact),
        .secondary_force_input(sfi), .input_format_bits(ifb));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        cyc(1);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        cyc(1);
        reg_wr = 1'b0;
    endtask
    task automatic rc(input string nm, input logic [6:0] a, input logic [7:0] exp);
        cyc(1);
        {reg_addr, reg_rd} = {a, 1'b1};
        cyc(1);
        reg_rd = 1'b0;
        cyc(1);
        chk(nm, reg_rdata, exp);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        {rst_n, rate_family_strap, reg_wr, reg_rd, primary_ref_changed, triple_sync_pin_mode} = 6'b010000;
        {locked_to_sync_source, input_nine_monitor_valid, phase_alarm_active, sync_pulse_in, apll_source_cfg} = 5'b01000;
        {reg_addr, reg_wdata, primary_state} = 18'h0;
        cyc(5);
        rst_n = 1'b1;
        for (int i = 0; i < 6; i++) rc("reset value", 7'h31 + 7'(i), rv[i]);
        for (int i = 0; i < 6; i++) begin
            wr(7'h31 + 7'(i), wv[i]);
            rc("readback", 7'h31 + 7'(i), xv[i]);
        end
        chk("controls", {1'b0, fre, lpoe, oes, frh, rfs, rev, aop}, 8'h3b);
        chk("force inputs", {pfi, sfi}, 8'h96);
        chk("format and flags", {ifb, 1'b0, pfim, srev, sfact}, 8'h57);
        apll_source_cfg = 1'b1;
        cyc(1);
        chk("apll", {6'h0, aop, ass}, 8'h01);
        for (int c = 0; c < 16; c++) begin
            ok = (c >= 1 && c <= 6) || c == 8 || c == 9;
            wr(7'h33, 8'(c));
            wr(7'h35, 8'(c));
            chk("force fields", {prf, srf}, {2{4'(c)}});
            chk("force code", {pfi, sfi}, ok ? {2{4'(c)}} : 8'h00);
            chk("force flags", {5'h0, pfa, pfim, sfact}, {5'h0, ok, ok, ok});
        end
        for (int s = 0; s < 8; s++) begin
            primary_state = 3'(s);
            wr(7'h32, 8'h10 | 8'(s));
            chk("state", {psf, sfa, lpoe, lpo, 2'b00}, {3'(s), s != 0, 1'b1, s == 4, 2'b00});
        end
        wr(7'h32, 8'h00);
        chk("lock off", {6'h0, lpoe, lpo}, 8'h00);
        wr(7'h31, 8'h00);
        chk("nine forced", {7'h0, n9v}, 8'h00);
        wr(7'h31, 8'h01);
        chk("nine normal", {7'h0, n9v}, 8'h01);
        wr(7'h34, 8'h88);
        chk("sync unlocked", {7'h0, fsg}, 8'h00);
        {locked_to_sync_source, sync_pulse_in} = 2'b11;
        cyc(3);
        chk("sync locked", {6'h0, fsg, spa}, 8'h03);
        locked_to_sync_source = 1'b0;
        wr(7'h34, 8'h08);
        chk("sync manual", {7'h0, fsg}, 8'h01);
        wr(7'h34, 8'h00);
        chk("sync off", {6'h0, fsg, spa}, 8'h00);
        triple_sync_pin_mode = 1'b1;
        wr(7'h34, 8'h88);
        primary_ref_changed = 1'b1;
        cyc(1);
        primary_ref_changed = 1'b0;
        rc("auto clear", 7'h34, 8'h80);
        wr(7'h34, 8'h40);
        phase_alarm_active = 1'b1;
        for (n = 0; n < 40 && pac !== 1'b1; n++) cyc(1);
        chk("alarm cancel", 8'(n), 8'h14);
        if (n == 40) results();
        wr(7'h34, 8'h00);
        n = 0;
        for (int k = 0; k < 40; k++) begin
            cyc(1);
            n += (pac === 1'b1);
        end
        chk("alarm kept", 8'(n), 8'h00);
        rate_family_strap = 1'b0;
        wr(7'h33, 8'h05);
        wr(7'h32, 8'h80);
        chk("soft reset", {7'h0, lrst}, 8'h01);
        wr(7'h33, 8'h01);
        rc("soft master_config_one", 7'h32, 8'ha0);
        rc("soft force", 7'h33, 8'h0f);
        rc("strap kept", 7'h34, 8'hce);
        wr(7'h32, 8'h00);
        rc("after soft", 7'h33, 8'h0f);
        rc("unmapped", 7'h40, 8'h00);
        results();
    end
endmodule
